// ==== inc/taoi_pkg.sv ====
// Package: register map, field positions and timing for the transmit overhead inserter
package taoi_pkg;
	// ----------------------------------------------------------------
	// Register offsets on the processor port
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_ALARM_CONFIG      = 8'h45;
	localparam logic [7:0] ADDR_ALARM_STATUS_FIRST   = 8'h47;
	localparam logic [7:0] ADDR_ALARM_STATUS_THIRD   = 8'h49;
	localparam logic [7:0] ADDR_TX_FRAME_FORMAT      = 8'h70;
	localparam logic [7:0] ADDR_TX_FRAME_OVERHEAD    = 8'h72;
	localparam logic [7:0] ADDR_TX_MANUAL_OVERHEAD   = 8'h74;
	localparam logic [7:0] ADDR_TX_ALARM_CTRL        = 8'h75;
	localparam logic [7:0] REG_RESET                 = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	// tx_frame_format: [1:0] T1 format, [2] E1, [3] E1 CAS multiframe
	localparam int FMT_E1_BIT    = 2;
	localparam int FMT_CAS_BIT   = 3;
	localparam logic [1:0] T1_SF   = 2'h0;
	localparam logic [1:0] T1_ESF  = 2'h1;
	localparam logic [1:0] T1_SUB  = 2'h2;	// 96-channel subscriber carrier
	localparam logic [1:0] T1_DM   = 2'h3;
	// tx_frame_overhead_ctrl
	localparam int OVH_YEL_INS   = 0;
	localparam int OVH_MYEL_INS  = 1;
	localparam int OVH_CRC_INS   = 2;
	localparam int OVH_AUTO_FE   = 3;
	localparam int OVH_JAPAN_YEL = 4;
	// tx_manual_overhead_ctrl
	localparam int MAN_FE_EN     = 0;
	localparam int MAN_E_FIRST   = 1;
	localparam int MAN_E_SECOND  = 2;
	// tx_alarm_ctrl
	localparam int ALM_MAN_YEL   = 0;
	localparam int ALM_AUTOMATIC_YELLOW_ENABLE  = 1;
	localparam int ALM_MAN_MYEL  = 2;
	localparam int ALM_AUTOMATIC_MULTIFRAME_YELLOW_ENABLE = 3;
	// rx_alarm_config
	localparam int CFG_INTEG     = 0;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] T1_LAST_BIT  = 8'hC0;	// 193 bits per frame
	localparam logic [7:0] E1_LAST_BIT  = 8'hFF;	// 256 bits per frame
	localparam logic [4:0] SF_LAST_FRM  = 5'h0B;
	localparam logic [4:0] ESF_LAST_FRM = 5'h17;
	localparam logic [4:0] E1_LAST_FRM  = 5'h0F;
	localparam logic [5:0] CRC6_POLY    = 6'h03;	// x^6 + x + 1
	localparam logic [5:0] CRC4_POLY    = 6'h03;	// x^4 + x + 1, low four bits

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CLK_HZ        = 40000000;
	localparam longint LOF_ONSET_MS  = 2500;	// about 2.5 s
	localparam longint YEL_HOLD_MS   = 1000;	// at least 1 s
	localparam longint LOF_ONSET_CYC = (LOF_ONSET_MS * CLK_HZ + 999) / 1000;
	localparam longint YEL_HOLD_CYC  = (YEL_HOLD_MS * CLK_HZ + 999) / 1000;

	// One bit slot of the transmit stream
	typedef struct packed {
		logic valid;	// bit present this cycle
		logic sync;	// first bit of a multiframe
		logic data;
	} taoi_bit_t;
endpackage

// ==== verilog/taoi_inserter.sv ====
// Transmit yellow alarm, multiframe yellow, CRC and E-bit overhead inserter
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// How it works
// - SF/ESF/subscriber carrier yellow: bit 2 zero
// - Japanese SF yellow: F-bit 12 forced one
// - T1DM yellow: sync byte Y bit zero
// - E1 remote alarm: TS0 A bit one
// - Bit-2 overwrite only with yellow insert enable
// - Manual yellow bit forces alarm pattern immediately
// - Auto yellow follows receive frame loss
// - Integration delays frame loss about 2.5 s
// - Integrated auto yellow held one second after
// - E1 CAS: TS16 frame 0 Y bit one
// - Multiframe yellow only with its insert enable
// - Manual multiframe yellow also needs its insert enable
// - Auto multiframe yellow follows CAS alignment loss
// - CRC-6 for T1, CRC-4 for E1
// - ESF check-bit channel carries CRC-6
// - E1 TS0 check bits carry CRC-4
// - Received CRC-4 error sends E bit zero
// - Format bit 3 selects E1 CAS multiframe
// ----------------------------------------------------------------
module taoi_inserter
	import taoi_pkg::*;
#(
	parameter longint LOF_ONSET_CYCLES = LOF_ONSET_CYC,
	parameter longint YEL_HOLD_CYCLES  = YEL_HOLD_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic [7:0] cpu_addr,
	input  wire logic [7:0] cpu_wdata,
	input  wire logic       cpu_wr_en,
	input  wire logic       cpu_rd_en,
	output var  logic [7:0] cpu_rdata,
	input  wire taoi_bit_t  tx_pcm_input,
	input  wire logic       raw_frame_loss_status,
	input  wire logic       cas_multiframe_alignment_lost,
	input  wire logic       rx_crc4_error,
	output var  taoi_bit_t  tx_line_out,
	output var  logic       rx_frame_alignment_lost,
	output var  logic       yellow_sending
);
	// Timers are 31 bits wide; refuse counts they cannot hold
	if (LOF_ONSET_CYCLES < 1 || LOF_ONSET_CYCLES > 64'h7FFFFFFF ||
	    YEL_HOLD_CYCLES < 1 || YEL_HOLD_CYCLES > 64'h7FFFFFFF) begin : g_bad_timer
		$error("taoi_inserter: timer counts out of range");
	end

	logic [7:0] rx_alarm_config;
	logic [7:0] tx_frame_format_field;
	logic [7:0] tx_frame_overhead_ctrl;
	logic [7:0] tx_manual_overhead_ctrl;
	logic [7:0] tx_alarm_ctrl;
	logic [30:0] lof_cnt;
	logic [30:0] hold_cnt;
	logic        lof_integrated;
	logic [7:0]  bit_pos;
	logic [4:0]  frm_cnt;
	logic [5:0]  crc_run;
	logic [5:0]  crc_hold;
	logic        fe_pending;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	// Processor writes; read-only status addresses ignore writes
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rx_alarm_config         <= REG_RESET;
			tx_frame_format_field   <= REG_RESET;
			tx_frame_overhead_ctrl  <= REG_RESET;
			tx_manual_overhead_ctrl <= REG_RESET;
			tx_alarm_ctrl           <= REG_RESET;
		end else if (cpu_wr_en) begin
			unique case (cpu_addr)
				ADDR_RX_ALARM_CONFIG:    rx_alarm_config         <= cpu_wdata;
				ADDR_TX_FRAME_FORMAT:    tx_frame_format_field   <= cpu_wdata;
				ADDR_TX_FRAME_OVERHEAD:  tx_frame_overhead_ctrl  <= cpu_wdata;
				ADDR_TX_MANUAL_OVERHEAD: tx_manual_overhead_ctrl <= cpu_wdata;
				ADDR_TX_ALARM_CTRL:      tx_alarm_ctrl           <= cpu_wdata;
				default: ;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cpu_rdata <= REG_RESET;
		end else if (cpu_rd_en) begin
			unique case (cpu_addr)
				ADDR_RX_ALARM_CONFIG:    cpu_rdata <= rx_alarm_config;
				ADDR_ALARM_STATUS_FIRST: cpu_rdata <= {7'h00, rx_frame_alignment_lost};
				ADDR_ALARM_STATUS_THIRD: cpu_rdata <= {5'h00, yellow_sending,
					cas_multiframe_alignment_lost, raw_frame_loss_status};
				ADDR_TX_FRAME_FORMAT:    cpu_rdata <= tx_frame_format_field;
				ADDR_TX_FRAME_OVERHEAD:  cpu_rdata <= tx_frame_overhead_ctrl;
				ADDR_TX_MANUAL_OVERHEAD: cpu_rdata <= tx_manual_overhead_ctrl;
				ADDR_TX_ALARM_CTRL:      cpu_rdata <= tx_alarm_ctrl;
				default:                 cpu_rdata <= REG_RESET;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Frame loss integration and yellow hold
	// ----------------------------------------------------------------
	logic integ_on;
	logic automatic_yellow_enable_cond;
	logic yellow_req;
	logic myel_req;
	assign integ_on = rx_alarm_config[CFG_INTEG];
	// Hold timer extends the alarm only when integrating
	assign automatic_yellow_enable_cond = rx_frame_alignment_lost | (integ_on & (hold_cnt != 31'h0));
	assign yellow_req = tx_alarm_ctrl[ALM_MAN_YEL] |
		(tx_alarm_ctrl[ALM_AUTOMATIC_YELLOW_ENABLE] & automatic_yellow_enable_cond);
	assign myel_req = tx_alarm_ctrl[ALM_MAN_MYEL] |
		(tx_alarm_ctrl[ALM_AUTOMATIC_MULTIFRAME_YELLOW_ENABLE] & cas_multiframe_alignment_lost);

	// Continuous out-of-frame must last the whole onset time; a gap restarts it
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			lof_cnt        <= 31'h0;
			lof_integrated <= 1'b0;
		end else if (!raw_frame_loss_status) begin
			lof_cnt        <= 31'h0;
			lof_integrated <= 1'b0;
		end else if (lof_cnt == 31'(LOF_ONSET_CYCLES - 1)) begin
			lof_integrated <= 1'b1;
		end else begin
			lof_cnt <= lof_cnt + 31'h1;
		end
	end

	// Reported frame loss, raw or integrated
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			rx_frame_alignment_lost <= 1'b0;
		else
			rx_frame_alignment_lost <= integ_on ? lof_integrated : raw_frame_loss_status;
	end

	// Reload hold while loss stands, count down after it clears
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			hold_cnt <= 31'h0;
		else if (rx_frame_alignment_lost)
			hold_cnt <= 31'(YEL_HOLD_CYCLES);
		else if (hold_cnt != 31'h0)
			hold_cnt <= hold_cnt - 31'h1;
	end

	// ----------------------------------------------------------------
	// Frame position
	// ----------------------------------------------------------------
	logic       is_e1;
	logic       is_cas;
	logic [1:0] t1_fmt;
	logic [7:0] last_bit;
	logic [4:0] last_frm;
	logic [7:0] cur_bit;
	logic [4:0] cur_frm;
	logic [7:0] pay;
	logic [4:0] slot;
	logic [2:0] bit_in_slot;
	logic       fbit;
	assign is_e1  = tx_frame_format_field[FMT_E1_BIT];
	assign is_cas = is_e1 & tx_frame_format_field[FMT_CAS_BIT];
	assign t1_fmt = tx_frame_format_field[1:0];
	assign last_bit = is_e1 ? E1_LAST_BIT : T1_LAST_BIT;
	assign last_frm = is_e1 ? E1_LAST_FRM : (t1_fmt == T1_ESF) ? ESF_LAST_FRM : SF_LAST_FRM;
	// A sync bit restarts the count at the first bit of frame 0
	assign cur_bit = tx_pcm_input.sync ? 8'h00 : bit_pos;
	assign cur_frm = tx_pcm_input.sync ? 5'h00 : frm_cnt;
	assign fbit = !is_e1 && cur_bit == 8'h00;
	assign pay = is_e1 ? cur_bit : cur_bit - 8'h01;
	assign slot = pay[7:3];
	assign bit_in_slot = pay[2:0];

	// Advance on each stream bit
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bit_pos <= 8'h00;
			frm_cnt <= 5'h00;
		end else if (tx_pcm_input.valid) begin
			if (cur_bit >= last_bit) begin
				bit_pos <= 8'h00;
				frm_cnt <= (cur_frm >= last_frm) ? 5'h00 : cur_frm + 5'h01;
			end else begin
				bit_pos <= cur_bit + 8'h01;
				frm_cnt <= cur_frm;
			end
		end
	end

	// ----------------------------------------------------------------
	// Overhead overwrite
	// ----------------------------------------------------------------
	logic crc_on;
	logic esf_crc_pos;
	logic e1_crc_pos;
	logic e_bit_pos;
	logic crc_bit;
	logic e_bit;
	logic next_out;
	logic crc_in;
	logic crc_fb;
	logic [5:0] crc_next;
	logic blk_end;
	assign crc_on = tx_frame_overhead_ctrl[OVH_CRC_INS];
	// ESF check bits on F-bits of frames 2,6,...,22 (counted from one)
	assign esf_crc_pos = fbit && t1_fmt == T1_ESF && cur_frm[1:0] == 2'h1;
	// E1 check bits: Si of FAS frames in each half multiframe
	assign e1_crc_pos = is_e1 && cur_bit == 8'h00 && !cur_frm[0] && !cur_frm[3]
		|| is_e1 && cur_bit == 8'h00 && !cur_frm[0] && cur_frm[3];
	// E bits: Si of frames 13 and 15
	assign e_bit_pos = is_e1 && cur_bit == 8'h00 && (cur_frm == 5'h0D || cur_frm == 5'h0F);
	assign crc_bit = is_e1 ? crc_hold[3 - cur_frm[2:1]] : crc_hold[5 - (cur_frm / 5'h04)];
	// Manual E bits override; auto sends one zero at the next E bit after any received errors
	assign e_bit = tx_manual_overhead_ctrl[MAN_FE_EN] ?
		tx_manual_overhead_ctrl[cur_frm == 5'h0D ? MAN_E_FIRST : MAN_E_SECOND] :
		!(tx_frame_overhead_ctrl[OVH_AUTO_FE] && fe_pending);

	// Later overwrites take priority within one bit position
	always_comb begin
		next_out = tx_pcm_input.data;
		if (!is_e1 && t1_fmt != T1_DM && !tx_frame_overhead_ctrl[OVH_JAPAN_YEL]) begin
			if (yellow_req && tx_frame_overhead_ctrl[OVH_YEL_INS]
			    && !fbit && bit_in_slot == 3'h1)
				next_out = 1'b0;
		end
		if (!is_e1 && t1_fmt == T1_SF && tx_frame_overhead_ctrl[OVH_JAPAN_YEL]
		    && fbit && cur_frm == 5'h0B && yellow_req)
			next_out = 1'b1;
		if (!is_e1 && t1_fmt == T1_DM && !fbit && slot == 5'h17
		    && bit_in_slot == 3'h5 && yellow_req)
			next_out = 1'b0;
		if (is_e1 && cur_frm[0] && slot == 5'h00 && bit_in_slot == 3'h2 && yellow_req)
			next_out = 1'b1;
		if (is_cas && cur_frm == 5'h00 && slot == 5'h10 && bit_in_slot == 3'h5
		    && myel_req && tx_frame_overhead_ctrl[OVH_MYEL_INS])
			next_out = 1'b1;
		if (crc_on && esf_crc_pos)
			next_out = crc_bit;
		if (crc_on && e1_crc_pos && !e_bit_pos && cur_frm[2:0] != 3'h6 + 3'h1)
			next_out = crc_bit;
		// E bits pass through unless a block-error source is enabled
		if (e_bit_pos && (tx_manual_overhead_ctrl[MAN_FE_EN]
		    || tx_frame_overhead_ctrl[OVH_AUTO_FE]))
			next_out = e_bit;
	end

	// CRC runs on sent data, check positions forced (ESF check bits to one, E1 C bits to zero)
	assign crc_in = esf_crc_pos ? 1'b1 : fbit && t1_fmt == T1_ESF ? next_out :
		(is_e1 && e1_crc_pos && cur_frm[2:0] != 3'h7) ? 1'b0 : next_out;
	assign crc_fb = crc_in ^ (is_e1 ? crc_run[3] : crc_run[5]);
	assign crc_next = is_e1 ? {2'h0, crc_run[2:0], 1'b0} ^ (crc_fb ? CRC4_POLY : 6'h00)
		: {crc_run[4:0], 1'b0} ^ (crc_fb ? CRC6_POLY : 6'h00);
	// ESF block is the multiframe; E1 block is each eight-frame half
	assign blk_end = cur_bit >= last_bit && (is_e1 ? cur_frm[2:0] == 3'h7 : cur_frm >= last_frm);

	// Result of one block goes out in the next block
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			crc_run  <= 6'h00;
			crc_hold <= 6'h00;
		end else if (tx_pcm_input.valid) begin
			if (tx_pcm_input.sync && bit_pos != 8'h00) begin
				crc_run <= crc_next;	// realignment keeps accumulating the running block
			end else if (blk_end) begin
				crc_hold <= crc_next;
				crc_run  <= 6'h00;
			end else begin
				crc_run <= crc_next;
			end
		end
	end

	// Error arriving while an E bit consumes the last one stays pending
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			fe_pending <= 1'b0;
		else if (rx_crc4_error)
			fe_pending <= 1'b1;
		else if (tx_pcm_input.valid && e_bit_pos)
			fe_pending <= 1'b0;
	end

	// Registered stream and alarm status
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tx_line_out    <= '0;
			yellow_sending <= 1'b0;
		end else begin
			tx_line_out.valid <= tx_pcm_input.valid;
			tx_line_out.sync  <= tx_pcm_input.valid & tx_pcm_input.sync;
			tx_line_out.data  <= tx_pcm_input.valid ? next_out : 1'b0;
			yellow_sending    <= yellow_req;
		end
	end
endmodule
`default_nettype wire

// ==== verif/taoi_far_end.sv ====
// Far-end line receiver model: frames the transmitted line into an image
`timescale 1ns/1ps
`default_nettype none
module taoi_far_end
	import taoi_pkg::*;
(
	input wire logic      ref_clk,
	input wire logic      e1_mode,
	input wire taoi_bit_t line_in
);
	// ----------
	// Frame alignment
	// ----------
	logic [7:0] pos;
	logic [4:0] frm;
	logic [7:0] cp;
	logic [4:0] cf;
	logic [7:0] last;
	logic       img [0:23][0:255];
	// Marker restarts the count, otherwise advance
	assign cp = line_in.sync ? 8'h00 : pos;
	assign cf = line_in.sync ? 5'h00 : frm;
	assign last = e1_mode ? E1_LAST_BIT : T1_LAST_BIT;
	// Store each bit where the framer placed it; gaps are skipped
	always_ff @(posedge ref_clk) begin
		if (line_in.valid) begin
			img[cf][cp] <= line_in.data;
			pos <= (cp == last) ? 8'h00 : cp + 8'h01;
			frm <= (cp == last) ? cf + 5'h01 : cf;
		end
	end
endmodule
`default_nettype wire

// ==== verif/taoi_inserter_checker.sv ====
// Checker: port-level alarm and status timing of the overhead inserter
`timescale 1ns/1ps
`default_nettype none
module taoi_inserter_checker
	import taoi_pkg::*;
#(
	parameter longint LOF_ONSET_CYCLES = 50,
	parameter longint YEL_HOLD_CYCLES  = 20
) (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic [7:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic       cpu_wr_en,
	input wire logic       cpu_rd_en,
	input wire logic [7:0] cpu_rdata,
	input wire taoi_bit_t  tx_pcm_input,
	input wire logic       raw_frame_loss_status,
	input wire logic       cas_multiframe_alignment_lost,
	input wire logic       rx_crc4_error,
	input wire taoi_bit_t  tx_line_out,
	input wire logic       rx_frame_alignment_lost,
	input wire logic       yellow_sending
);
	// ----------
	// Helper state
	// ----------
	logic [3:0] alm;
	logic       integ;
	longint     run;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Mirror alarm control from the write port, not from inside
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			alm <= 4'h0;
		else if (cpu_wr_en && cpu_addr == ADDR_TX_ALARM_CTRL)
			alm <= cpu_wdata[3:0];
	end
	// Mirror integration enable
	always_ff @(posedge ref_clk) begin
		if (!rstn)
			integ <= 1'b0;
		else if (cpu_wr_en && cpu_addr == ADDR_RX_ALARM_CONFIG)
			integ <= cpu_wdata[0];
	end
	// Length of the current raw loss run
	always_ff @(posedge ref_clk) begin
		if (!rstn || !raw_frame_loss_status)
			run <= 0;
		else
			run <= run + 1;
	end
	sequence hold_s;
		yellow_sending [*8];
	endsequence
	// ----------
	// Properties
	// ----------
	bit_follow_a: assert property (tx_pcm_input.valid |=> tx_line_out.valid)
		else $error("line bit missing after input bit");
	idle_quiet_a: assert property (!tx_pcm_input.valid |=> tx_line_out == '0)
		else $error("line active without input bit");
	manual_yellow_a: assert property (alm[0] |=> yellow_sending)
		else $error("manual yellow not sent");
	auto_yellow_a: assert property (alm[1] && !integ && raw_frame_loss_status |-> ##[1:2] yellow_sending)
		else $error("auto yellow not sent");
	yellow_off_a: assert property (!alm[0] && !alm[1] |=> !yellow_sending)
		else $error("yellow without a source");
	lof_follow_a: assert property (!integ |=> rx_frame_alignment_lost == $past(raw_frame_loss_status))
		else $error("frame loss status not following raw");
	onset_early_a: assert property (integ && $rose(rx_frame_alignment_lost) |-> run >= LOF_ONSET_CYCLES)
		else $error("integrated loss set too early");
	onset_late_a: assert property (integ && run == LOF_ONSET_CYCLES + 4 |-> rx_frame_alignment_lost)
		else $error("integrated loss set too late");
	hold_after_a: assert property (integ && alm[1] && $fell(rx_frame_alignment_lost) |-> hold_s)
		else $error("yellow dropped before hold time");
endmodule
bind taoi_inserter taoi_inserter_checker #(
	.LOF_ONSET_CYCLES(LOF_ONSET_CYCLES),
	.YEL_HOLD_CYCLES(YEL_HOLD_CYCLES)
) u_taoi_inserter_checker (
	.ref_clk, .rstn, .cpu_addr, .cpu_wdata, .cpu_wr_en, .cpu_rd_en, .cpu_rdata,
	.tx_pcm_input, .raw_frame_loss_status, .cas_multiframe_alignment_lost,
	.rx_crc4_error, .tx_line_out, .rx_frame_alignment_lost, .yellow_sending
);
`default_nettype wire

// ==== verif/taoi_inserter_test.sv ====
// Self-checking bench for the transmit overhead inserter
`timescale 1ns/1ps
`default_nettype none
module taoi_inserter_test
	import taoi_pkg::*;
;
	// ----------
	// Stimulus state
	// ----------
	localparam int LOF = 50;
	localparam int HOLD = 20;
	localparam logic [7:0] REGS [7] = '{8'h45, 8'h47, 8'h49, 8'h70, 8'h72, 8'h74, 8'h75};
	logic       ref_clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] cpu_addr = 8'h00;
	logic [7:0] cpu_wdata = 8'h00;
	logic [7:0] cpu_rdata;
	logic       cpu_wr_en = 1'b0;
	logic       cpu_rd_en = 1'b0;
	logic       raw = 1'b0;
	logic       cas = 1'b0;
	logic       crc_err = 1'b0;
	taoi_bit_t  pcm = '0;
	taoi_bit_t  line;
	logic       lost;
	logic       yel;
	logic [3:0] fmt;
	logic [7:0] ovh, man, r;
	logic       yel_x, myel_x;
	logic [3:0] c4;
	logic       sent [0:23][0:255];
	int         seed = 32'h35EF;
	int         miscompares = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         n;
	always #12.5 ref_clk = ~ref_clk;
	taoi_inserter #(.LOF_ONSET_CYCLES(LOF), .YEL_HOLD_CYCLES(HOLD)) u_taoi_inserter (
		.ref_clk, .rstn, .cpu_addr, .cpu_wdata, .cpu_wr_en, .cpu_rd_en, .cpu_rdata,
		.tx_pcm_input(pcm), .raw_frame_loss_status(raw), .cas_multiframe_alignment_lost(cas),
		.rx_crc4_error(crc_err), .tx_line_out(line), .rx_frame_alignment_lost(lost),
		.yellow_sending(yel));
	taoi_far_end u_taoi_far_end (.ref_clk, .e1_mode(fmt[2]), .line_in(line));
	// Hang guard, well above the expected run length
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk8(logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (e !== g) begin
			miscompares++;
			$display("[FAIL] t=%0t exp=%0h got=%0h", $time, e, g);
		end
	endtask
	task automatic chk1(logic e, logic g);
		chk8({7'h00, e}, {7'h00, g});
	endtask
	task automatic rst_dut();
		rstn = 1'b0;
		repeat (12) tick();
		rstn = 1'b1;
	endtask
	// Strobes drop for one cycle so back-to-back calls never reassign them in one step
	task automatic wr(logic [7:0] a, logic [7:0] d);
		cpu_addr = a;
		cpu_wdata = d;
		cpu_wr_en = 1'b1;
		tick();
		cpu_wr_en = 1'b0;
		tick();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		cpu_addr = a;
		cpu_rd_en = 1'b1;
		tick();
		cpu_rd_en = 1'b0;
		d = cpu_rdata;
		tick();
	endtask
	// Expected line bit: {checked, value}; second-half CRC-4 comes from c4
	function automatic logic [1:0] exp_bit(int f, int b, logic d);
		logic [1:0] x;
		x = {1'b1, d};
		if (fmt[2]) begin
			if (yel_x && b == 2 && f[0]) x[0] = 1'b1;
			if (fmt[3] && ovh[1] && myel_x && f == 0 && b == 133) x[0] = 1'b1;
			if (b == 0 && (f == 13 || f == 15) && man[0]) x[0] = man[f == 13 ? 1 : 2];
			else if (b == 0 && (f == 13 || f == 15) && ovh[3]) x[0] = (f == 15);
			if (ovh[2] && b == 0 && !f[0]) x[0] = (f < 8) ? 1'b0 : c4[3 - (f % 8) / 2];
		end else begin
			if (ovh[0] && yel_x && fmt[1:0] != T1_DM && b > 0 && (b - 1) % 8 == 1) x[0] = 1'b0;
			if (ovh[4] && yel_x && fmt[1:0] == T1_SF && f == 11 && b == 0) x[0] = 1'b1;
			if (yel_x && fmt[1:0] == T1_DM && b == 190) x[0] = 1'b0;
			if (ovh[2] && fmt[1:0] == T1_ESF && b == 0 && f % 4 == 1) x[0] = 1'b0;
		end
		return x;
	endfunction
	// One multiframe of random data in the given mode, then compare the far-end image
	task automatic run(logic [3:0] f_, logic [7:0] o_, logic [7:0] m_, logic [7:0] a_,
			logic r_, logic c_, logic e_);
		int nf, nb;
		logic [1:0] x;
		fmt = f_;
		ovh = o_;
		man = m_;
		yel_x = a_[0] | (a_[1] & r_);
		myel_x = a_[2] | (a_[3] & c_);
		rst_dut();
		wr(ADDR_TX_FRAME_FORMAT, {4'h0, f_});
		wr(ADDR_TX_FRAME_OVERHEAD, o_);
		wr(ADDR_TX_MANUAL_OVERHEAD, m_);
		wr(ADDR_TX_ALARM_CTRL, a_);
		raw = r_;
		cas = c_;
		crc_err = e_;
		tick();
		crc_err = 1'b0;
		repeat (3) tick();
		nf = f_[2] ? 16 : (f_[1:0] == T1_ESF ? 24 : 12);
		nb = f_[2] ? 256 : 193;
		for (int f = 0; f < nf; f++) begin
			for (int b = 0; b < nb; b++) begin
				sent[f][b] = 1'($random(seed));
				pcm = {1'b1, f == 0 && b == 0, sent[f][b]};
				tick();
				if (($random(seed) & 7) == 0) begin
					pcm = '0;
					tick();
				end
			end
		end
		pcm = '0;
		repeat (2) tick();
		c4 = 4'h0;
		for (int f = 0; f < nf; f++) begin
			for (int b = 0; b < nb; b++) begin
				x = exp_bit(f, b, sent[f][b]);
				if (x[1]) chk1(x[0], u_taoi_far_end.img[f][b]);
				// First-half CRC-4 over the sent bits, check positions already zero
				if (f < 8) c4 = {c4[2:0], 1'b0} ^ ((x[0] ^ c4[3]) ? CRC4_POLY[3:0] : 4'h0);
			end
		end
		raw = 1'b0;
		cas = 1'b0;
		$display("mode %0h done", f_);
	endtask
	initial begin
		fmt = 4'h0;
		rst_dut();
		foreach (REGS[i]) begin
			rd(REGS[i], r);
			chk8(8'h00, r);
		end
		wr(ADDR_TX_ALARM_CTRL, 8'h01);
		rd(ADDR_TX_ALARM_CTRL, r);
		chk8(8'h01, r);
		chk1(1'b1, yel);
		wr(8'h50, 8'hFF);
		wr(ADDR_ALARM_STATUS_FIRST, 8'hFF);
		rd(8'h50, r);
		chk8(8'h00, r);
		rd(ADDR_ALARM_STATUS_FIRST, r);
		chk8(8'h00, r);
		rst_dut();
		wr(ADDR_TX_ALARM_CTRL, 8'h02);
		raw = 1'b1;
		repeat (3) tick();
		chk1(1'b1, lost);
		chk1(1'b1, yel);
		rd(ADDR_ALARM_STATUS_FIRST, r);
		chk8(8'h01, r);
		rd(ADDR_ALARM_STATUS_THIRD, r);
		chk8(8'h05, r);
		raw = 1'b0;
		rst_dut();
		wr(ADDR_RX_ALARM_CONFIG, 8'h01);
		wr(ADDR_TX_ALARM_CTRL, 8'h02);
		raw = 1'b1;
		for (n = 0; lost !== 1'b1 && n < 200; n++) tick();
		chk1(1'b1, n >= LOF && n <= LOF + 3);
		repeat (6) tick();
		raw = 1'b0;
		for (n = 0; lost === 1'b1 && n < 10; n++) tick();
		for (n = 0; yel === 1'b1 && n < 200; n++) tick();
		chk1(1'b1, n >= HOLD && n <= HOLD + 3);
		$display("register and status done");
		run(4'h0, 8'h01, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		run(4'h0, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		run(4'h1, 8'h01, 8'h00, 8'h02, 1'b1, 1'b0, 1'b0);
		run(4'h2, 8'h01, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		run(4'h0, 8'h10, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		run(4'h3, 8'h00, 8'h00, 8'h02, 1'b1, 1'b0, 1'b0);
		run(4'h4, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
		run(4'hC, 8'h02, 8'h00, 8'h04, 1'b0, 1'b0, 1'b0);
		run(4'hC, 8'h00, 8'h00, 8'h04, 1'b0, 1'b0, 1'b0);
		run(4'hC, 8'h02, 8'h00, 8'h08, 1'b0, 1'b1, 1'b0);
		run(4'h4, 8'h00, 8'h03, 8'h00, 1'b0, 1'b0, 1'b0);
		run(4'h1, 8'h03, 8'h00, 8'h04, 1'b0, 1'b0, 1'b0);
		run(4'h4, 8'h08, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
		run(4'h1, 8'h04, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
		run(4'h4, 8'h04, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
		close_out();
	end
endmodule
`default_nettype wire
